// File: include/odt_pkg.sv
// package for the termination timing block: latency limits and types
// assumes a single 100 MHz clock standing in for the memory clock
package odt_pkg;
  // clock period in ns, used to derive async delay counts
  localparam int CLK_PERIOD_NS = 10;
  // asynchronous turn-on/turn-off delays, ns (scaled by 10 for 8.5)
  localparam int ASYNC_MIN_NS_X10 = 20;
  localparam int ASYNC_MAX_NS_X10 = 85;
  // least time rounds up, at least one cycle
  localparam int ASYNC_DLY_CYC_RAW =
    (ASYNC_MIN_NS_X10 + CLK_PERIOD_NS * 10 - 1) / (CLK_PERIOD_NS * 10);
  localparam int ASYNC_DLY_CYC =
    (ASYNC_DLY_CYC_RAW < 1) ? 1 : ASYNC_DLY_CYC_RAW;
  // fixed widths of latency fields, delay line depth and latency offset
  localparam int CWL_W        = 4;
  localparam int AL_W         = 2;
  localparam int LAT_W        = 5;
  localparam int PIPE_DEPTH   = 32;
  localparam int LAT_OFFSET   = 2;
  // minimum high times in cycles
  localparam int HOLD_BC4     = 4;
  localparam int HOLD_BL8     = 6;
  // additive latency field encodings and the zero latency reset value
  localparam logic [AL_W-1:0] AL_ZERO = 2'h0;
  localparam logic [AL_W-1:0] AL_CL1  = 2'h1;
  localparam logic [AL_W-1:0] AL_CL2  = 2'h2;
  localparam logic [LAT_W-1:0] LAT_RST = 5'h00;

  typedef struct packed {
    logic             dll_locked;
    logic             dll_off_ppd;
    logic             nom_en;
    logic             wr_en;
    logic [CWL_W-1:0] cwl;
    logic [CWL_W-1:0] cl;
    logic [AL_W-1:0]  al_sel;
  } odt_cfg_t;

  typedef enum logic [1:0] {
    MODE_IGNORE,
    MODE_SYNC,
    MODE_ASYNC
  } odt_mode_t;
endpackage : odt_pkg

// File: hw/odt_delay_line.sv
// delay line memory holding past odt samples, one bit per cycle
// assumes reader picks a tap no deeper than the line length
`timescale 1ns/1ns
module odt_delay_line
  import odt_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             din,
  input  wire logic [LAT_W-1:0] tap,
  output logic                  dout
);
  logic [PIPE_DEPTH-1:0] line_q;
  logic [PIPE_DEPTH-1:0] line_d;
  logic                  dout_d;

  always_comb begin
    line_d = {line_q[PIPE_DEPTH-2:0], din};
    // tap 0 means the current sample itself
    dout_d = (tap == LAT_RST) ? din : line_q[tap - 5'h01];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      line_q <= '0;
      dout   <= 1'b0;
    end else begin
      line_q <= line_d;
      dout   <= dout_d;
    end
  end
endmodule : odt_delay_line

// File: hw/odt_termination_timing.sv
// termination timing: decides when on-die termination turns on and off
// assumes odt and write command are sampled synchronous to clk
`timescale 1ns/1ns
module odt_termination_timing
  import odt_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire logic     odt,
  input  wire logic     wr_cmd,
  input  wire logic     wr_bl8,
  input  wire logic     ppd_active,
  input  odt_cfg_t      cfg,
  output logic          rtt_on,
  output odt_mode_t     mode,
  output logic          hold_viol
);
  logic [LAT_W-1:0] al_cyc;
  logic [LAT_W-1:0] odtl;
  logic             sync_tap;
  logic             any_term;
  odt_mode_t        mode_d;
  logic             rtt_d;
  logic [ASYNC_DLY_CYC-1:0] async_q;
  logic [ASYNC_DLY_CYC-1:0] async_d;
  logic [2:0]       hold_q;
  logic [2:0]       hold_d;
  logic             odt_q;
  logic             viol_d;

  // additive latency in cycles from its field and cas latency
  function automatic logic [LAT_W-1:0] al_cycles(
    input logic [AL_W-1:0]  sel,
    input logic [CWL_W-1:0] cl
  );
    unique case (sel)
      AL_CL1:  al_cycles = LAT_W'(cl) - 5'h01;
      AL_CL2:  al_cycles = LAT_W'(cl) - 5'h02;
      default: al_cycles = LAT_RST;
    endcase
  endfunction : al_cycles

  // on latency CWL+AL-2; off latency is the same
  // additive latency folded into the one tap
  always_comb begin
    al_cyc = al_cycles(cfg.al_sel, cfg.cl);
    odtl   = LAT_W'(cfg.cwl) + al_cyc - LAT_W'(LAT_OFFSET);
  end

  // one shared tap serves on and off, since both latencies match
  odt_delay_line u_line (
    .clk  (clk),
    .rst  (rst),
    .din  (odt),
    .tap  (odtl - 5'h01),
    .dout (sync_tap)
  );

  always_comb begin
    any_term = cfg.nom_en | cfg.wr_en;
    // no termination enabled means odt is ignored
    if (!any_term)
      mode_d = MODE_IGNORE;
    // dll not yet locked after reset, or ppd active with dll off in ppd
    else if (!cfg.dll_locked || (ppd_active && cfg.dll_off_ppd))
      mode_d = MODE_ASYNC;
    else
      mode_d = MODE_SYNC;
  end

  // async path samples odt directly, no additive latency
  // turn-on one clock later, the 2 ns minimum rounded up to a whole clock
  // turn-off uses the same fixed delay
  always_comb begin
    // odt enters at the top and walks down to bit 0
    async_d = ASYNC_DLY_CYC'({odt, async_q} >> 1);
    unique case (mode_d)
      MODE_SYNC:  rtt_d = sync_tap;
      MODE_ASYNC: rtt_d = async_q[0];
      default:    rtt_d = 1'b0;
    endcase
  end

  // one counter keeps the later of the two minimum high times
  always_comb begin
    hold_d = (hold_q != 3'h0) ? hold_q - 3'h1 : 3'h0;
    viol_d = 1'b0;
    // four cycles from odt registered high
    if (odt && !odt_q && hold_d < 3'(HOLD_BC4 - 1))
      hold_d = 3'(HOLD_BC4 - 1);
    // write with odt high extends the hold
    if (odt && wr_cmd) begin
      if (wr_bl8 && hold_d < 3'(HOLD_BL8 - 1))
        hold_d = 3'(HOLD_BL8 - 1);
      else if (!wr_bl8 && hold_d < 3'(HOLD_BC4 - 1))
        hold_d = 3'(HOLD_BC4 - 1);
    end
    // flag only; the device cannot refuse an early fall
    if (!odt && odt_q && hold_q != 3'h0)
      viol_d = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      async_q   <= '0;
      hold_q    <= 3'h0;
      odt_q     <= 1'b0;
      rtt_on    <= 1'b0;
      mode      <= MODE_IGNORE;
      hold_viol <= 1'b0;
    end else begin
      async_q   <= async_d;
      hold_q    <= hold_d;
      odt_q     <= odt;
      rtt_on    <= rtt_d;
      mode      <= mode_d;
      hold_viol <= viol_d;
    end
  end

  // checker helpers: an odt history and an independent count of the
  // high stretch, so the checks do not lean on the design's own counter
  logic [PIPE_DEPTH-1:0] hist_q;
  logic [PIPE_DEPTH-1:0] hist_d;
  logic [LAT_W-1:0]      odtl_q;
  logic [2:0]            hi_cnt_q;
  logic [2:0]            hi_cnt_d;
  logic [2:0]            wr_age_q;
  logic [2:0]            wr_age_d;
  logic [2:0]            wr_need_q;
  logic [2:0]            wr_need_d;
  logic                  short_hi;

  always_comb begin
    hist_d    = {hist_q[PIPE_DEPTH-2:0], odt};
    hi_cnt_d  = 3'h0;
    if (odt)
      hi_cnt_d = (hi_cnt_q == 3'h7) ? hi_cnt_q : hi_cnt_q + 3'h1;
    wr_age_d  = (wr_age_q == 3'h7) ? wr_age_q : wr_age_q + 3'h1;
    wr_need_d = odt ? wr_need_q : 3'h0;
    if (odt && wr_cmd) begin
      wr_age_d  = 3'h1;
      wr_need_d = wr_bl8 ? 3'(HOLD_BL8) : 3'(HOLD_BC4);
    end
    // only the latest write is tracked, so this flags real breaks only
    short_hi  = !odt && (hi_cnt_q != 3'h0) &&
                ((hi_cnt_q < 3'(HOLD_BC4)) || (wr_age_q < wr_need_q));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hist_q    <= '0;
      odtl_q    <= LAT_RST;
      hi_cnt_q  <= 3'h0;
      wr_age_q  <= 3'h7;
      wr_need_q <= 3'h0;
    end else begin
      hist_q    <= hist_d;
      odtl_q    <= odtl;
      hi_cnt_q  <= hi_cnt_d;
      wr_age_q  <= wr_age_d;
      wr_need_q <= wr_need_d;
    end
  end

  // checks
  a_ignore_off: assert property (@(posedge clk) disable iff (rst)
    !(cfg.nom_en | cfg.wr_en) |=> !rtt_on)
    else $error("termination on while disabled");
  a_async_follow: assert property (@(posedge clk) disable iff (rst)
    (mode_d == MODE_ASYNC) && odt ##1 (mode_d == MODE_ASYNC) |=> rtt_on)
    else $error("async turn-on late");
  a_async_off: assert property (@(posedge clk) disable iff (rst)
    (mode_d == MODE_ASYNC) && !odt ##1 (mode_d == MODE_ASYNC) |=> !rtt_on)
    else $error("async turn-off late");
  a_sync_on: assert property (@(posedge clk) disable iff (rst)
    mode == MODE_SYNC && odtl != LAT_RST && odtl == odtl_q &&
    $stable(odtl_q) && hist_q[odtl] |-> rtt_on)
    else $error("sync turn-on latency wrong");
  a_sync_off: assert property (@(posedge clk) disable iff (rst)
    mode == MODE_SYNC && odtl != LAT_RST && odtl == odtl_q &&
    $stable(odtl_q) && !hist_q[odtl] |-> !rtt_on)
    else $error("sync turn-off latency wrong");
  a_mode_sync: assert property (@(posedge clk) disable iff (rst)
    cfg.dll_locked && !ppd_active && (cfg.nom_en | cfg.wr_en)
    |=> mode == MODE_SYNC)
    else $error("sync mode not selected");
  a_mode_async: assert property (@(posedge clk) disable iff (rst)
    !cfg.dll_locked && (cfg.nom_en | cfg.wr_en)
    |=> mode == MODE_ASYNC)
    else $error("async mode not selected");
  a_ppd_async: assert property (@(posedge clk) disable iff (rst)
    ppd_active && cfg.dll_off_ppd && (cfg.nom_en | cfg.wr_en)
    |=> mode == MODE_ASYNC)
    else $error("ppd dll-off not async");
  a_hold_flag: assert property (@(posedge clk) disable iff (rst)
    odt && !$past(odt) ##1 !odt |=> hold_viol)
    else $error("short odt pulse not flagged");
  a_bl8_flag: assert property (@(posedge clk) disable iff (rst)
    odt && wr_cmd && wr_bl8 ##1 odt[*4] ##1 !odt |=> hold_viol)
    else $error("short bl8 hold not flagged");
  a_bc4_flag: assert property (@(posedge clk) disable iff (rst)
    odt && wr_cmd && !wr_bl8 ##1 odt[*2] ##1 !odt |=> hold_viol)
    else $error("short bc4 hold not flagged");
  a_short_flag: assert property (@(posedge clk) disable iff (rst)
    short_hi |=> hold_viol)
    else $error("broken high time not flagged");
  a_legal_quiet: assert property (@(posedge clk) disable iff (rst)
    !odt && hi_cnt_q >= 3'(HOLD_BC4) &&
    (wr_need_q == 3'h0 || wr_age_q >= 3'(HOLD_BL8)) |=> !hold_viol)
    else $error("legal high time flagged");

  c_sync_on: cover property (@(posedge clk) mode == MODE_SYNC && rtt_on);
  c_async_on: cover property (@(posedge clk)
    mode == MODE_ASYNC && rtt_on);
  c_viol: cover property (@(posedge clk) hold_viol);
  c_al_sync: cover property (@(posedge clk)
    mode == MODE_SYNC && cfg.al_sel != AL_ZERO && rtt_on);
  c_ignore_odt: cover property (@(posedge clk) mode == MODE_IGNORE && odt);
endmodule : odt_termination_timing

// File: test/odt_ctrl_model.sv
// controller model: drives odt pulses and write commands
// assumes go is seen for one falling edge per pulse
`timescale 1ns/1ns
module odt_ctrl_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       legal,
  input  wire logic [3:0] len,
  input  wire logic [3:0] wr_at,
  input  wire logic       bl8,
  output logic            odt,
  output logic            wr_cmd,
  output logic            wr_bl8
);
  int n = 0;
  int k = 0;
  int need;
  initial begin
    odt = 1'b0;
    wr_cmd = 1'b0;
    wr_bl8 = 1'b0;
  end
  always @(negedge clk) begin
    if (go) begin
      need = (wr_at != 0) ? wr_at + (bl8 ? 6 : 4) : 4;
      // illegal pulses only when a scenario asks for them
      n = (legal && need > len) ? need : len;
      k = 0;
    end
    // odt low between pulses, reads fit there
    odt = (k < n);
    wr_cmd = odt && wr_at != 0 && k == wr_at;
    wr_bl8 = bl8;
    k = k + 1;
  end
endmodule : odt_ctrl_model

// File: test/odt_termination_timing_tb.sv
// bench: controller model drives odt, monitor checks rtt_on timing
// assumes mode and latency follow cfg one cycle before odt moves
`timescale 1ns/1ns
module odt_termination_timing_tb;
  import odt_pkg::*;
  logic clk = 0, rst = 1, go = 0, legal = 1, bl8 = 0, ppd = 0, lo = 0;
  logic [3:0] len = 4, wr_at = 0;
  logic odt, wr_cmd, wr_bl8, rtt_on, hold_viol, lr = 0;
  logic [7:0] r = 8'h04;
  odt_mode_t mode;
  odt_cfg_t cfg = '{1'b1, 1'b1, 1'b1, 1'b0, 4'h5, 4'h6, AL_ZERO};
  int cyc = 0, nhv = 0, failures = 0, n_compared = 0, q_cyc[$];
  logic q_val[$];
  odt_ctrl_model i_odt_ctrl_model (.clk(clk), .go(go), .legal(legal),
    .len(len), .wr_at(wr_at), .bl8(bl8), .odt(odt), .wr_cmd(wr_cmd),
    .wr_bl8(wr_bl8));
  odt_termination_timing i_odt_termination_timing (.clk(clk), .rst(rst),
    .odt(odt), .wr_cmd(wr_cmd), .wr_bl8(wr_bl8), .ppd_active(ppd),
    .cfg(cfg), .rtt_on(rtt_on), .mode(mode), .hold_viol(hold_viol));
  always #5 clk = ~clk;
  function automatic odt_mode_t exp_mode();
    if (!(cfg.nom_en || cfg.wr_en)) return MODE_IGNORE;
    if ((ppd && cfg.dll_off_ppd) || !cfg.dll_locked) return MODE_ASYNC;
    return MODE_SYNC;
  endfunction : exp_mode
  function automatic int exp_lat();
    if (exp_mode() == MODE_ASYNC) return ASYNC_DLY_CYC;
    if (cfg.al_sel == AL_CL1) return cfg.cwl + cfg.cl - 3;
    if (cfg.al_sel == AL_CL2) return cfg.cwl + cfg.cl - 4;
    return cfg.cwl - 2;
  endfunction : exp_lat
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic print_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  // expected edge of each change noted as odt is registered
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (!rst && odt !== lo && exp_mode() != MODE_IGNORE) begin
      q_cyc.push_back(cyc + exp_lat());
      q_val.push_back(odt);
    end
    lo = odt;
  end
  always @(negedge clk) begin
    if (rtt_on !== lr) begin
      if (q_cyc.size() == 0) chk(1, 0, "unexpected change");
      else chk({cyc[30:0], rtt_on},
        {31'(q_cyc.pop_front()), q_val.pop_front()}, "termination edge");
    end
    lr = rtt_on;
    nhv = nhv + (hold_viol === 1'b1);
  end
  task automatic pulse(input int l, w, input logic b, lg);
    @(negedge clk);
    {len, wr_at, bl8, legal, go} <= {4'(l), 4'(w), b, lg, 1'b1};
    @(negedge clk);
    go <= 1'b0;
    repeat (l + 24) @(negedge clk);
    chk({30'h0, mode}, {30'h0, exp_mode()}, "mode");
  endtask : pulse
  initial begin
    repeat (8) @(negedge clk);
    rst <= 1'b0;
    pulse(4, 0, 0, 1);
    cfg.al_sel <= AL_CL1;
    pulse(5, 2, 1, 1);
    cfg.al_sel <= AL_CL2;
    pulse(4, 3, 0, 1);
    cfg.al_sel <= 2'h3;
    for (int i = 0; i < 6; i++) begin
      r = lfsr(r);
      cfg.cwl <= 4'h5 + 4'(r[4:3]);
      pulse(4 + r[2:0], r[7:6], r[5], 1);
    end
    chk(nhv, 0, "hold flag on legal pulses");
    pulse(2, 0, 0, 0);
    chk(nhv, 1, "hold flag on short pulse");
    pulse(6, 1, 1, 0);
    pulse(4, 1, 0, 0);
    chk(nhv, 3, "hold flag after short write hold");
    ppd <= 1'b1;
    pulse(4, 0, 0, 1);
    cfg.dll_off_ppd <= 1'b0;
    pulse(4, 0, 0, 1);
    {ppd, cfg.dll_off_ppd, cfg.dll_locked} <= 3'h2;
    pulse(4, 0, 0, 1);
    {cfg.dll_locked, cfg.nom_en} <= 2'h2;
    pulse(4, 0, 0, 1);
    cfg.wr_en <= 1'b1;
    pulse(6, 1, 0, 1);
    chk(q_cyc.size(), 0, "missing termination change");
    print_verdict();
  end
  initial begin
    #100000;
    failures++;
    print_verdict();
  end
endmodule : odt_termination_timing_tb
